// *** hw/sswdt_regs.svh ***
// register indexes, port addresses and timing constants of the watchdog
`ifndef SSWDT_REGS_SVH
`define SSWDT_REGS_SVH
// ----------------------------------------
// port addresses and unlock and lock keys
// ----------------------------------------
`define SSWDT_IDX_PORT 16'h002E
`define SSWDT_DAT_PORT 16'h002F
`define SSWDT_KEY_UNLOCK 8'h87
`define SSWDT_KEY_LOCK 8'hAA
// ----------------------------------------
// register indexes and values
// ----------------------------------------
`define SSWDT_IDX_LDN 8'h07
`define SSWDT_IDX_ACT 8'h30
`define SSWDT_IDX_TBASE 8'hF5
`define SSWDT_IDX_COUNT 8'hF6
`define SSWDT_LDN_WDT 8'h08
`define SSWDT_ACT_BIT 0
`define SSWDT_TB_MIN_BIT 3
`define SSWDT_RST_BYTE 8'h00
`define SSWDT_RD_IDLE 8'hFF
// ----------------------------------------
// timing
// ----------------------------------------
`define SSWDT_CLK_HZ 50000000
`define SSWDT_UNIT_SEC 1
`define SSWDT_SEC_PER_MIN 6'h3C
`endif

// *** hw/sswdt_pkg.sv ***
// types shared by the watchdog design
package sswdt_pkg;
	// one I/O cycle from the host side
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] data;
	} sswdt_io_t;
	// configuration lock states
	typedef enum logic [2:0] {
		SSWDT_LOCKED = 3'b001,
		SSWDT_HALF = 3'b010,
		SSWDT_CONFIG = 3'b100
	} sswdt_state_t;
endpackage

// *** hw/sswdt_top.sv ***
// watchdog logical device behind the index/data configuration ports
//
// Contract
// RQ1 - two unlock writes to index port enter config
// RQ2 - index 07 then 08 selects watchdog device
// RQ3 - index 30 enables or disables, anytime
// RQ4 - index F5 picks seconds (00) or minutes (08)
// RQ5 - index F6 count, zero disables timeout
// RQ6 - seconds base expires after exactly count seconds
// RQ7 - minutes base expires after exactly count minutes
// RQ8 - expiry while active drives system reset
// RQ9 - rewriting count reloads and restarts timing
// RQ10 - decrement per unit, expire reaching zero
`timescale 1ns/10ps
`include "sswdt_regs.svh"
module sswdt_top #(
	parameter int CYC_PER_SEC = `SSWDT_UNIT_SEC * `SSWDT_CLK_HZ
)(
	input wire logic clk,
	input wire logic rstn,
	input wire sswdt_pkg::sswdt_io_t io,
	output logic [7:0] ioRdata,
	output logic sysReset
);
	import sswdt_pkg::*;

	// ----------------------------------------
	// state and registers
	// ----------------------------------------
	sswdt_state_t state_reg; // lock state
	logic [7:0] idx_reg; // selected index
	logic [7:0] ldn_reg; // logical device number
	logic [7:0] act_reg; // activation
	logic [7:0] tbase_reg; // time base
	logic [7:0] cnt_reg; // loaded timeout count
	logic [7:0] remain_reg; // units left
	logic [25:0] pre_reg; // clock prescaler to one second
	logic [5:0] secs_reg; // seconds inside a minute
	logic [7:0] rdata_reg; // read answer
	logic sysReset_reg; // expiry reset level

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic idxWr; // write to index port
	logic datWr; // write to data port in config
	logic inCfg; // configuration mode
	logic wdtSel; // watchdog device selected
	logic actWr; // activation write
	logic tbWr; // time base write
	logic cntWr; // count write
	logic reload; // restart timing
	logic run; // countdown running
	logic minMode; // minute base
	logic secTick; // one second elapsed
	logic unitTick; // one unit elapsed

	// true when the watchdog device is selected and the index matches the given one
	function automatic logic hitIdx(input logic [7:0] idx, input logic [7:0] want, input logic sel);
		hitIdx = sel && (idx == want);
	endfunction

	assign inCfg = (state_reg == SSWDT_CONFIG);
	assign idxWr = io.wr && (io.addr == `SSWDT_IDX_PORT);
	assign datWr = io.wr && (io.addr == `SSWDT_DAT_PORT) && inCfg;
	assign wdtSel = (ldn_reg == `SSWDT_LDN_WDT); // [RQ2]
	assign actWr = datWr && hitIdx(idx_reg, `SSWDT_IDX_ACT, wdtSel);
	assign tbWr = datWr && hitIdx(idx_reg, `SSWDT_IDX_TBASE, wdtSel);
	assign cntWr = datWr && hitIdx(idx_reg, `SSWDT_IDX_COUNT, wdtSel);
	assign reload = cntWr || actWr || tbWr; // [RQ9]
	assign minMode = tbase_reg[`SSWDT_TB_MIN_BIT]; // [RQ4]
	// zero count or inactive device never counts
	assign run = act_reg[`SSWDT_ACT_BIT] && (remain_reg != `SSWDT_RST_BYTE) && !sysReset_reg; // [RQ5]
	assign secTick = run && (pre_reg == 26'(CYC_PER_SEC - 1)); // [RQ6]
	assign unitTick = secTick && (!minMode || (secs_reg == `SSWDT_SEC_PER_MIN - 6'h01)); // [RQ7]

	// ----------------------------------------
	// unlock sequence
	// ----------------------------------------
	// any other index write between keys aborts the unlock
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_reg <= SSWDT_LOCKED;
		else if (idxWr)
		begin
			unique case (state_reg)
				SSWDT_LOCKED:
					state_reg <= (io.data == `SSWDT_KEY_UNLOCK) ? SSWDT_HALF : SSWDT_LOCKED; // [RQ1]
				SSWDT_HALF:
					state_reg <= (io.data == `SSWDT_KEY_UNLOCK) ? SSWDT_CONFIG : SSWDT_LOCKED; // [RQ1]
				SSWDT_CONFIG:
					// leaving config keeps the watchdog running
					state_reg <= (io.data == `SSWDT_KEY_LOCK) ? SSWDT_LOCKED : SSWDT_CONFIG;
			endcase
		end
	end

	// ----------------------------------------
	// index and device select
	// ----------------------------------------
	// index latches only in config, so unlock keys never land as an index
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			idx_reg <= `SSWDT_RST_BYTE;
		else if (idxWr && inCfg)
			idx_reg <= io.data;
	end

	// device number is global, reachable whatever device is selected
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ldn_reg <= `SSWDT_RST_BYTE;
		else if (datWr && (idx_reg == `SSWDT_IDX_LDN))
			ldn_reg <= io.data; // [RQ2]
	end

	// ----------------------------------------
	// watchdog registers
	// ----------------------------------------
	// activation byte, only bit 0 gates the countdown
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			act_reg <= `SSWDT_RST_BYTE;
		else if (actWr)
			act_reg <= io.data; // [RQ3]
	end

	// time base byte, kept whole for read back
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tbase_reg <= `SSWDT_RST_BYTE;
		else if (tbWr)
			tbase_reg <= io.data; // [RQ4]
	end

	// stored count, reused when activation or time base restarts timing
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt_reg <= `SSWDT_RST_BYTE;
		else if (cntWr)
			cnt_reg <= io.data; // [RQ5]
	end

	// ----------------------------------------
	// time base
	// ----------------------------------------
	// prescaler restarts on reload so the first unit is a full one
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pre_reg <= 26'h0000000;
		else if (reload || !run || secTick)
			pre_reg <= 26'h0000000;
		else
			pre_reg <= pre_reg + 26'h0000001;
	end

	// seconds inside the current minute unit
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			secs_reg <= 6'h00;
		else if (reload || !run || unitTick)
			secs_reg <= 6'h00;
		else if (secTick)
			secs_reg <= secs_reg + 6'h01; // [RQ7]
	end

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	// a new count takes the written value, other reloads the stored one
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			remain_reg <= `SSWDT_RST_BYTE;
		else if (cntWr)
			remain_reg <= io.data; // [RQ9]
		else if (actWr || tbWr)
			remain_reg <= cnt_reg;
		else if (unitTick)
			remain_reg <= remain_reg - 8'h01; // [RQ10]
	end

	// reset level holds until software reloads or disables
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sysReset_reg <= 1'b0;
		else if (reload)
			sysReset_reg <= 1'b0; // [RQ3]
		else if (unitTick && (remain_reg == 8'h01))
			sysReset_reg <= 1'b1; // [RQ8]
	end

	// ----------------------------------------
	// read back
	// ----------------------------------------
	// data port reads show the live countdown at the count index
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata_reg <= `SSWDT_RD_IDLE;
		else if (io.rd)
		begin
			if (!inCfg)
				rdata_reg <= `SSWDT_RD_IDLE;
			else if (io.addr == `SSWDT_IDX_PORT)
				rdata_reg <= idx_reg;
			else if (io.addr != `SSWDT_DAT_PORT)
				rdata_reg <= `SSWDT_RD_IDLE;
			else if (idx_reg == `SSWDT_IDX_LDN)
				rdata_reg <= ldn_reg;
			else if (hitIdx(idx_reg, `SSWDT_IDX_ACT, wdtSel))
				rdata_reg <= act_reg;
			else if (hitIdx(idx_reg, `SSWDT_IDX_TBASE, wdtSel))
				rdata_reg <= tbase_reg;
			else if (hitIdx(idx_reg, `SSWDT_IDX_COUNT, wdtSel))
				rdata_reg <= remain_reg;
			else
				rdata_reg <= `SSWDT_RD_IDLE;
		end
	end

	// outputs leave straight from their flip-flops
	assign ioRdata = rdata_reg;
	assign sysReset = sysReset_reg;

	// ----------------------------------------
	// assertion helpers
	// ----------------------------------------
	// one minute unit in cycles; 32 bits since the product outgrows an int at full rate
	localparam logic [31:0] CYC_PER_MIN = 32'(`SSWDT_SEC_PER_MIN) * 32'(CYC_PER_SEC);
	logic [31:0] unitCyc_reg; // cycles since the current unit began

	// counted apart from the prescaler, so a broken prescaler cannot hide
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			unitCyc_reg <= 32'h00000000;
		else if (reload || !run || unitTick)
			unitCyc_reg <= 32'h00000000; // a new unit starts
		else
			unitCyc_reg <= unitCyc_reg + 32'h00000001;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_UNLOCK: assert property (@(posedge clk) disable iff (!rstn) // [RQ1]
		$rose(inCfg) |-> $past(state_reg == SSWDT_HALF && idxWr && io.data == `SSWDT_KEY_UNLOCK))
		else $error("config entered without double unlock");
	AST_LDN: assert property (@(posedge clk) disable iff (!rstn) // [RQ2]
		$changed(cnt_reg) |-> $past(wdtSel && inCfg))
		else $error("count changed without watchdog device");
	AST_DISABLE: assert property (@(posedge clk) disable iff (!rstn) // [RQ3]
		(actWr && io.data == `SSWDT_RST_BYTE) |=> !run && !sysReset ##1 !sysReset)
		else $error("disable not taken");
	AST_ZERO: assert property (@(posedge clk) disable iff (!rstn) // [RQ5]
		(cntWr && io.data == `SSWDT_RST_BYTE) ##1 !reload [*3] |-> !sysReset)
		else $error("zero count gave reset");
	AST_SEC: assert property (@(posedge clk) disable iff (!rstn) // [RQ6]
		(unitTick && !minMode) |-> $past(run && pre_reg == 26'(CYC_PER_SEC - 2)))
		else $error("second unit not one second");
	AST_MIN: assert property (@(posedge clk) disable iff (!rstn) // [RQ7]
		(unitTick && minMode) |-> unitCyc_reg == CYC_PER_MIN - 32'h00000001)
		else $error("minute unit not sixty seconds");
	AST_RST: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
		$rose(sysReset) |-> $past(remain_reg == 8'h01 && unitTick && act_reg[`SSWDT_ACT_BIT]))
		else $error("reset without expiry");
	AST_RELOAD: assert property (@(posedge clk) disable iff (!rstn) // [RQ9]
		cntWr |=> remain_reg == $past(io.data) && pre_reg == 26'h0000000)
		else $error("count write did not reload");
	AST_DEC: assert property (@(posedge clk) disable iff (!rstn) // [RQ10]
		(unitTick && !reload) |=> remain_reg == $past(remain_reg) - 8'h01)
		else $error("countdown step wrong");
	AST_UNIT_SEC: assert property (@(posedge clk) disable iff (!rstn) // [RQ6]
		(unitTick && !minMode) |-> unitCyc_reg == 32'(CYC_PER_SEC) - 32'h00000001)
		else $error("second unit length wrong");
	AST_STEP: assert property (@(posedge clk) disable iff (!rstn) // [RQ10]
		$changed(remain_reg) |-> $past(reload || unitTick))
		else $error("countdown moved without unit or reload");
	AST_HOLD: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
		$fell(sysReset) |-> $past(reload))
		else $error("reset request dropped without software");
	AST_IDLE_READ: assert property (@(posedge clk) disable iff (!rstn) // [RQ1]
		(io.rd && !inCfg) |=> ioRdata == `SSWDT_RD_IDLE)
		else $error("locked read did not answer idle");
	AST_GATE: assert property (@(posedge clk) disable iff (!rstn) // [RQ2]
		(datWr && !wdtSel && idx_reg != `SSWDT_IDX_LDN) |=> $stable(act_reg) && $stable(tbase_reg) && $stable(cnt_reg))
		else $error("watchdog register written with another device selected");

	// main scenarios: unlock, expiry, kick, minutes, aborted unlock
	COV_UNLOCK: cover property (@(posedge clk) disable iff (!rstn) $rose(inCfg));
	COV_EXPIRE: cover property (@(posedge clk) disable iff (!rstn) $rose(sysReset));
	COV_KICK: cover property (@(posedge clk) disable iff (!rstn) cntWr && run);
	COV_MIN: cover property (@(posedge clk) disable iff (!rstn) unitTick && minMode);
	COV_ABORT: cover property (@(posedge clk) disable iff (!rstn) state_reg == SSWDT_HALF && idxWr && io.data != `SSWDT_KEY_UNLOCK);
endmodule

// *** tb/tb_sswdt_top.sv ***
// self-checking testbench for the watchdog behind the index/data ports
`timescale 1ns/10ps
`include "sswdt_regs.svh"
module tb_sswdt_top;
	import sswdt_pkg::*;
	// ----------------------------------------
	// signals and counters
	// ----------------------------------------
	localparam int CPS = 10; // shortened second so long counts stay cheap
	logic clk; // 50 MHz bench clock
	logic rstn; // active-low reset
	sswdt_io_t io; // host I/O cycle
	logic [7:0] ioRdata; // read answer
	logic sysReset; // system reset request
	int nMismatch; // mismatches seen
	int checks; // comparisons made
	sswdt_top #(.CYC_PER_SEC(CPS)) uut (.clk(clk), .rstn(rstn), .io(io), .ioRdata(ioRdata), .sysReset(sysReset));
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	// half period of 10 ns gives 20 ns
	always #10 clk = ~clk;
	// cut a hang short well beyond the longest expected run
	initial
	begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		complete_run();
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe, released at the following edge
	task automatic iow(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) io <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(posedge clk) io <= '0;
	endtask
	// one-cycle read strobe; the answer is registered at the taking edge
	task automatic ior(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk) io <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(posedge clk) io <= '0;
		#1 check(ioRdata, exp);
	endtask
	// index write then data write
	task automatic setreg(input logic [7:0] idx, input logic [7:0] val);
		iow(`SSWDT_IDX_PORT, idx);
		iow(`SSWDT_DAT_PORT, val);
	endtask
	// index write then data read
	task automatic rdreg(input logic [7:0] idx, input logic [7:0] exp);
		iow(`SSWDT_IDX_PORT, idx);
		ior(`SSWDT_DAT_PORT, exp);
	endtask
	// idle for a fixed number of edges, then look at the reset request
	task automatic idle(input int n, input logic exp);
		repeat (n) @(posedge clk);
		#1 check({7'h00, sysReset}, {7'h00, exp});
	endtask
	// expiry must land within two cycles of t edges after the count write
	task automatic expiry(input int t);
		idle(t - 3, 1'b0);
		idle(4, 1'b1);
	endtask
	// verdict in one place
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		io = '0;
		nMismatch = 0;
		checks = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		// locked: reads idle, no reset request
		ior(`SSWDT_DAT_PORT, 8'hFF);
		idle(1, 1'b0);
		// a stray byte between keys starts over; a single key is not enough
		iow(`SSWDT_IDX_PORT, `SSWDT_KEY_UNLOCK);
		iow(`SSWDT_IDX_PORT, 8'h55);
		iow(`SSWDT_IDX_PORT, `SSWDT_KEY_UNLOCK);
		ior(`SSWDT_IDX_PORT, 8'hFF);
		ior(`SSWDT_DAT_PORT, 8'hFF);
		iow(`SSWDT_IDX_PORT, `SSWDT_KEY_UNLOCK);
		ior(`SSWDT_IDX_PORT, 8'h00);
		// device not yet selected: activation write must be dropped
		setreg(`SSWDT_IDX_ACT, 8'h01);
		setreg(`SSWDT_IDX_LDN, `SSWDT_LDN_WDT);
		rdreg(`SSWDT_IDX_LDN, 8'h08);
		rdreg(`SSWDT_IDX_ACT, 8'h00);
		// seconds base, three units
		setreg(`SSWDT_IDX_ACT, 8'h01);
		rdreg(`SSWDT_IDX_ACT, 8'h01);
		setreg(`SSWDT_IDX_TBASE, 8'h00);
		rdreg(`SSWDT_IDX_TBASE, 8'h00);
		setreg(`SSWDT_IDX_COUNT, 8'h03);
		expiry(3 * CPS);
		// the request is a level that stays until software acts
		idle(20, 1'b1);
		// zero count clears and never expires
		setreg(`SSWDT_IDX_COUNT, 8'h00);
		idle(100, 1'b0);
		// a kick mid-count restarts timing from the new write
		setreg(`SSWDT_IDX_COUNT, 8'h03);
		repeat (20) @(posedge clk);
		rdreg(`SSWDT_IDX_COUNT, 8'h01);
		setreg(`SSWDT_IDX_COUNT, 8'h03);
		expiry(3 * CPS);
		// disable mid-count, then re-enable restarts from the stored count
		setreg(`SSWDT_IDX_COUNT, 8'h02);
		repeat (5) @(posedge clk);
		setreg(`SSWDT_IDX_ACT, 8'h00);
		idle(60, 1'b0);
		setreg(`SSWDT_IDX_ACT, 8'h01);
		expiry(2 * CPS);
		// largest count at seconds base
		setreg(`SSWDT_IDX_COUNT, 8'hFF);
		expiry(255 * CPS);
		// minutes base, two units
		setreg(`SSWDT_IDX_COUNT, 8'h00);
		setreg(`SSWDT_IDX_TBASE, 8'h08);
		rdreg(`SSWDT_IDX_TBASE, 8'h08);
		setreg(`SSWDT_IDX_COUNT, 8'h02);
		expiry(2 * 60 * CPS);
		// leaving config mode hides the registers again
		iow(`SSWDT_IDX_PORT, `SSWDT_KEY_LOCK);
		ior(`SSWDT_DAT_PORT, 8'hFF);
		// reset mid-run drops the standing request
		@(posedge clk) rstn <= 1'b0;
		@(posedge clk) rstn <= 1'b1;
		idle(1, 1'b0);
		complete_run();
	end
endmodule
